// file: rtl/lcdr_consts.vh
`ifndef LCDR_CONSTS_VH
`define LCDR_CONSTS_VH
// ****************************************
// Target address and command fields
// ****************************************
`define LCDR_ADDR_FIXED      6'h1C
`define LCDR_BYTE_MSB        3'h7
`define LCDR_BIT_LAST        3'h0
`define LCDR_CONT_BIT        7
`define LCDR_RW_BIT          0
`define LCDR_SEL_BIT         1
`define LCDR_DSEL_PATTERN    4'hC
`define LCDR_PTR_MAX         6'h27
`define LCDR_PTR_ZERO        6'h00
`define LCDR_SUB_ZERO        3'h0
`define LCDR_ADDR_LO         2
`define LCDR_DSEL_HI         6
`define LCDR_DSEL_LO         3
`define LCDR_LPTR_BIT        6
`define LCDR_SUB_HI          2
`define LCDR_PTR_HI          5
`define LCDR_BIT_ZERO        4'h0
`define LCDR_BIT_ACK         4'h8
`define LCDR_BIT_HOLD        4'h9
`define LCDR_FIFO_WIDTH      14
`define LCDR_FIFO_DEPTH      8
`define LCDR_FIFO_AW         3
`endif

// file: rtl/lcdr_fifo.v
`timescale 1ns/100ps
// ****************************************
// Write FIFO
// ****************************************
module lcdr_fifo #(
    parameter WIDTH = 14,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             sys_clk,
    input  wire             nrst,
    input  wire             clk_en,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_reg;
    reg [AW-1:0]    rd_reg;
    reg [AW:0]      cnt_reg;
    wire            push;
    wire            pop;

    assign in_ready  = (cnt_reg != DEPTH[AW:0]);
    assign out_valid = (cnt_reg != {(AW+1){1'b0}});
    assign out_data  = mem[rd_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge sys_clk) begin
        if (clk_en && push) begin
            mem[wr_reg] <= in_data;
        end
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_reg  <= {AW{1'b0}};
            rd_reg  <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
        end else if (clk_en) begin
            if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule // lcdr_fifo

// file: rtl/lcdr_rx.v
`timescale 1ns/100ps
`include "lcdr_consts.vh"
// Function
// - Detect START: data falls, clock high
// - Detect STOP: data rises, clock high
// - Eight bits MSB first, then acknowledge
// - Hold data low through acknowledge high
// - Receive only; acknowledge is only output
// - Answer addresses 0111000 and 0111001
// - Address bit 1 must match strap
// - Never acknowledge a read request
// - Command MSB zero ends commands; acknowledge
// - Store data at pointer, then advance it; subaddress steps on wrap
// - Acknowledge data only on subaddress match
// - Selection uses address, commands, subaddress pins
// - Accept STOP or repeated START
// - Bit 7 of command is continuation flag
// - Device-select pattern 1100 loads subaddress
// - Load-pointer command loads six-bit pointer
module lcdr_rx (
    sys_clk,
    nrst,
    clk_en,
    scl_in,
    sda_in,
    sda_out,
    sda_oe_n,
    addr_select_strap,
    hw_subaddr_pin_0,
    hw_subaddr_pin_1,
    hw_subaddr_pin_2,
    wr_valid,
    wr_ready,
    wr_addr,
    wr_sub,
    wr_data,
    cmd_valid,
    cmd_data,
    busy
);
    input  wire        sys_clk;
    input  wire        nrst;
    input  wire        clk_en;
    input  wire        scl_in;
    input  wire        sda_in;
    output wire        sda_out;
    output wire        sda_oe_n;
    input  wire        addr_select_strap;
    input  wire        hw_subaddr_pin_0;
    input  wire        hw_subaddr_pin_1;
    input  wire        hw_subaddr_pin_2;
    output wire        wr_valid;
    input  wire        wr_ready;
    output wire [5:0]  wr_addr;
    output wire [2:0]  wr_sub;
    output wire [7:0]  wr_data;
    output reg         cmd_valid;
    output reg  [7:0]  cmd_data;
    output wire        busy;

    // ****************************************
    // Phase encoding
    // ****************************************
    localparam PH_IDLE = 3'b000;
    localparam PH_ADDR = 3'b001;
    localparam PH_CMD  = 3'b010;
    localparam PH_DATA = 3'b011;
    localparam PH_SKIP = 3'b100;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // All pins are asynchronous; two flops before any logic looks at them
    reg  [1:0] scl_sync_reg;
    reg  [1:0] sda_sync_reg;
    reg  [2:0] sub_sync0_reg;
    reg  [2:0] sub_sync1_reg;
    reg  [1:0] strap_sync_reg;
    reg        scl_d_reg;
    reg        sda_d_reg;

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            scl_sync_reg   <= 2'h3;
            sda_sync_reg   <= 2'h3;
            sub_sync0_reg  <= 3'h0;
            sub_sync1_reg  <= 3'h0;
            strap_sync_reg <= 2'h0;
            scl_d_reg      <= 1'b1;
            sda_d_reg      <= 1'b1;
        end else if (clk_en) begin
            scl_sync_reg   <= {scl_sync_reg[0], scl_in};
            sda_sync_reg   <= {sda_sync_reg[0], sda_in};
            sub_sync0_reg  <= {hw_subaddr_pin_2, hw_subaddr_pin_1, hw_subaddr_pin_0};
            sub_sync1_reg  <= sub_sync0_reg;
            strap_sync_reg <= {strap_sync_reg[0], addr_select_strap};
            scl_d_reg      <= scl_sync_reg[1];
            sda_d_reg      <= sda_sync_reg[1];
        end
    end

    wire scl_s    = scl_sync_reg[1];
    wire sda_s    = sda_sync_reg[1];
    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    // Data edges with clock high are conditions, never bits
    wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    // ****************************************
    // Byte receiver state
    // ****************************************
    reg  [2:0] ph_reg;
    reg  [2:0] ph_next;
    reg  [7:0] shift_reg;
    reg  [3:0] bit_reg;
    reg        ack_slot_reg;
    reg        ack_want_reg;
    reg        ack_drv_reg;
    reg  [5:0] ptr_reg;
    reg  [2:0] sub_reg;

    // Counter runs 0 to 7 over the data bits, 8 before the ack, 9 while it stands
    wire [7:0] byte_now = {shift_reg[6:0], sda_s};
    wire       bit_take = scl_rise & ~ack_slot_reg;
    wire       byte_end = bit_take & (bit_reg == {1'b0, `LCDR_BYTE_MSB});
    wire       ack_open = scl_fall & ack_slot_reg & (bit_reg == `LCDR_BIT_ACK);
    wire       ack_shut = scl_fall & ack_slot_reg & (bit_reg == `LCDR_BIT_HOLD);
    wire       abandon  = stop_det | start_det;

    // ****************************************
    // Byte decoding
    // ****************************************
    wire addr_ok = (byte_now[`LCDR_CONT_BIT:`LCDR_ADDR_LO] == `LCDR_ADDR_FIXED)
                 & (byte_now[`LCDR_SEL_BIT] == strap_sync_reg[1])
                 & ~byte_now[`LCDR_RW_BIT];
    wire is_last = ~byte_now[`LCDR_CONT_BIT];
    wire is_dsel = (byte_now[`LCDR_DSEL_HI:`LCDR_DSEL_LO] == `LCDR_DSEL_PATTERN);
    wire is_lptr = ~byte_now[`LCDR_LPTR_BIT];
    // Only the selected cascade member acknowledges data; a full FIFO refuses it
    wire sub_match = (sub_reg == sub_sync1_reg);
    wire sub_ok    = sub_match & wr_ready;
    // Unselected members still walk pointer and subaddress to stay in step
    wire advance   = ~sub_match | wr_ready;
    wire [5:0] ptr_inc = (ptr_reg == `LCDR_PTR_MAX) ? `LCDR_PTR_ZERO : ptr_reg + 6'h01;

    assign wr_valid = (ph_reg == PH_DATA) & byte_end & sub_ok;
    assign wr_addr  = ptr_reg;
    assign wr_sub   = sub_reg;
    assign wr_data  = byte_now;
    assign sda_out  = 1'b0;
    assign sda_oe_n = ~ack_drv_reg;
    assign busy     = (ph_reg != PH_IDLE);

    // ****************************************
    // Phase control
    // ****************************************
    always @* begin
        ph_next = ph_reg;
        if (stop_det) begin
            ph_next = PH_IDLE;
        end else if (start_det) begin
            ph_next = PH_ADDR;
        end else if (byte_end) begin
            case (ph_reg)
                PH_ADDR: begin
                    ph_next = addr_ok ? PH_CMD : PH_SKIP;
                end
                PH_CMD: begin
                    ph_next = is_last ? PH_DATA : PH_CMD;
                end
                default: begin
                    ph_next = ph_reg;
                end
            endcase
        end
    end

    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ph_reg <= PH_IDLE;
        end else if (clk_en) begin
            ph_reg <= ph_next;
        end
    end

    // ****************************************
    // Bit counter and shifter
    // ****************************************
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            shift_reg    <= 8'h00;
            bit_reg      <= `LCDR_BIT_ZERO;
            ack_slot_reg <= 1'b0;
        end else if (clk_en) begin
            if (abandon) begin
                bit_reg      <= `LCDR_BIT_ZERO;
                ack_slot_reg <= 1'b0;
            end else if (bit_take) begin
                shift_reg <= byte_now;
                bit_reg   <= bit_reg + 4'h1;
                if (byte_end) begin
                    ack_slot_reg <= 1'b1;
                end
            end else if (ack_open) begin
                bit_reg <= `LCDR_BIT_HOLD;
            end else if (ack_shut) begin
                bit_reg      <= `LCDR_BIT_ZERO;
                ack_slot_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // Acknowledge decision
    // ****************************************
    // Decided at the eighth bit, before the phase and the pointer move on
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ack_want_reg <= 1'b0;
        end else if (clk_en) begin
            if (abandon) begin
                ack_want_reg <= 1'b0;
            end else if (byte_end) begin
                case (ph_reg)
                    PH_ADDR: begin
                        ack_want_reg <= addr_ok;
                    end
                    PH_CMD: begin
                        ack_want_reg <= 1'b1;
                    end
                    PH_DATA: begin
                        ack_want_reg <= sub_ok;
                    end
                    default: begin
                        ack_want_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Acknowledge drive
    // ****************************************
    // Pull starts after the eighth clock falls, so it covers the whole ninth high phase
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ack_drv_reg <= 1'b0;
        end else if (clk_en) begin
            if (abandon) begin
                ack_drv_reg <= 1'b0;
            end else if (ack_open) begin
                ack_drv_reg <= ack_want_reg;
            end else if (ack_shut) begin
                ack_drv_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // Command output
    // ****************************************
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cmd_valid <= 1'b0;
            cmd_data  <= 8'h00;
        end else if (clk_en) begin
            cmd_valid <= 1'b0;
            if (byte_end && (ph_reg == PH_CMD)) begin
                cmd_valid <= 1'b1;
                cmd_data  <= byte_now;
            end
        end
    end

    // ****************************************
    // Data pointer and subaddress counter
    // ****************************************
    // Device-select is tested first, though its pattern has bit 6 set and load-pointer needs bit 6 clear
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ptr_reg <= `LCDR_PTR_ZERO;
            sub_reg <= `LCDR_SUB_ZERO;
        end else if (clk_en && byte_end) begin
            if (ph_reg == PH_CMD) begin
                if (is_dsel) begin
                    sub_reg <= byte_now[`LCDR_SUB_HI:0];
                end else if (is_lptr) begin
                    ptr_reg <= byte_now[`LCDR_PTR_HI:0];
                end
            end else if ((ph_reg == PH_DATA) && advance) begin
                ptr_reg <= ptr_inc;
                if (ptr_reg == `LCDR_PTR_MAX) begin
                    sub_reg <= sub_reg + 3'h1;
                end
            end
        end
    end
endmodule // lcdr_rx

// file: rtl/lcdr_top.v
`timescale 1ns/100ps
`include "lcdr_consts.vh"
// ****************************************
// Receiver with write FIFO
// ****************************************
module lcdr_top (
    input  wire        sys_clk,
    input  wire        nrst,
    input  wire        clk_en,
    input  wire        scl_in,
    input  wire        sda_in,
    output wire        sda_out,
    output wire        sda_oe_n,
    input  wire        addr_select_strap,
    input  wire        hw_subaddr_pin_0,
    input  wire        hw_subaddr_pin_1,
    input  wire        hw_subaddr_pin_2,
    output wire        ram_valid,
    input  wire        ram_ready,
    output wire [13:0] ram_word,
    output wire        cmd_valid,
    output wire [7:0]  cmd_data,
    output wire        busy
);
    wire       wr_valid;
    wire       wr_ready;
    wire [5:0] wr_addr;
    wire [2:0] wr_sub;
    wire [7:0] wr_data;

    lcdr_rx u_rx (
        .sys_clk           (sys_clk),
        .nrst              (nrst),
        .clk_en            (clk_en),
        .scl_in            (scl_in),
        .sda_in            (sda_in),
        .sda_out           (sda_out),
        .sda_oe_n          (sda_oe_n),
        .addr_select_strap (addr_select_strap),
        .hw_subaddr_pin_0  (hw_subaddr_pin_0),
        .hw_subaddr_pin_1  (hw_subaddr_pin_1),
        .hw_subaddr_pin_2  (hw_subaddr_pin_2),
        .wr_valid          (wr_valid),
        .wr_ready          (wr_ready),
        .wr_addr           (wr_addr),
        .wr_sub            (wr_sub),
        .wr_data           (wr_data),
        .cmd_valid         (cmd_valid),
        .cmd_data          (cmd_data),
        .busy              (busy)
    );

    // FIFO holds pointer and data; subaddress is implied by the ack
    lcdr_fifo #(
        .WIDTH (`LCDR_FIFO_WIDTH),
        .DEPTH (`LCDR_FIFO_DEPTH),
        .AW    (`LCDR_FIFO_AW)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .clk_en    (clk_en),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   ({wr_addr, wr_data}),
        .out_valid (ram_valid),
        .out_ready (ram_ready),
        .out_data  (ram_word)
    );
endmodule // lcdr_top

// file: tb/lcdr_checker.sv
`timescale 1ns/100ps
// ********************
// Receiver checks
// ********************
module lcdr_checker (
    input wire        sys_clk,
    input wire        nrst,
    input wire        scl_in,
    input wire        sda_in,
    input wire        sda_out,
    input wire        sda_oe_n,
    input wire        ram_valid,
    input wire        ram_ready,
    input wire [13:0] ram_word,
    input wire        cmd_valid,
    input wire        busy
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Pin view is unsynchronised, so margins cover the two-flop lag
    sequence bus_start; scl_in && $past(scl_in) && $fell(sda_in); endsequence
    sequence bus_stop; scl_in && $past(scl_in) && $rose(sda_in); endsequence
    a_only_ack: assert property (sda_out == 1'b0)
        else $error("data output not low");
    a_ack_in_frame: assert property (!sda_oe_n |-> busy)
        else $error("line pulled outside a transfer");
    a_start_busy: assert property (bus_start |-> ##[1:6] busy)
        else $error("start not seen");
    a_stop_idle: assert property (bus_stop |-> ##[1:6] !busy)
        else $error("stop not seen");
    a_ack_holds: assert property (scl_in && $past(scl_in) && !$past(sda_oe_n) |-> !sda_oe_n)
        else $error("acknowledge dropped while clock high");
    a_no_late_ack: assert property (scl_in && $past(scl_in) && $past(sda_oe_n) |-> sda_oe_n)
        else $error("line pulled while clock high");
    a_ack_bounded: assert property ($fell(sda_oe_n) |-> ##[4:24] sda_oe_n)
        else $error("acknowledge never released");
    a_cmd_pulse: assert property (cmd_valid |-> busy ##1 !cmd_valid)
        else $error("command strobe wrong");
    a_ram_hold: assert property (ram_valid && !ram_ready |=> ram_valid && $stable(ram_word))
        else $error("display word lost");
    a_ptr_range: assert property (ram_valid |-> ram_word[13:8] <= 6'h27)
        else $error("pointer out of range");
endmodule // lcdr_checker

bind lcdr_top lcdr_checker u_chk (.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .ram_valid(ram_valid),
    .ram_ready(ram_ready), .ram_word(ram_word), .cmd_valid(cmd_valid), .busy(busy));

// file: tb/lcdr_bus_ctrl.sv
`timescale 1ns/100ps
// ********************
// Bus controller model
// ********************
module lcdr_bus_ctrl (
    input  wire  sys_clk,
    input  wire  sda_line,
    output logic scl,
    output logic sda_drv
);
    // High drive means released; the pull-up makes the level
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task q;
        repeat (2) @(posedge sys_clk);
    endtask
    // Also used mid-byte for a repeated start
    task start;
        sda_drv <= 1'b1;
        q;
        scl <= 1'b1;
        q;
        sda_drv <= 1'b0;
        q;
        scl <= 1'b0;
        q;
    endtask
    task stop;
        sda_drv <= 1'b0;
        q;
        scl <= 1'b1;
        q;
        sda_drv <= 1'b1;
        q;
        q;
    endtask
    task send(input [7:0] b, input integer n, output logic ack);
        integer i;
        ack = 1'b1;
        for (i = 0; i < n; i++) begin
            sda_drv <= b[7 - i];
            q;
            scl <= 1'b1;
            q;
            q;
            scl <= 1'b0;
            q;
        end
        if (n == 8) begin
            sda_drv <= 1'b1;
            q;
            scl <= 1'b1;
            repeat (4) begin
                @(posedge sys_clk);
                ack = ack & !sda_line;
            end
            scl <= 1'b0;
            q;
        end else ack = 1'b0;
    endtask
endmodule // lcdr_bus_ctrl

// file: tb/test_lcdr_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
// ********************
// Bench
// ********************
module test_lcdr_top;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        ram_ready = 1'b1;
    logic        strap = 1'b0;
    logic [2:0]  hw_sub = 3'h0;
    logic        ack;
    logic [7:0]  last_cmd;
    logic [13:0] words[$];
    wire         scl, sda_drv, sda_out, sda_oe_n, ram_valid, cmd_valid, busy;
    wire  [13:0] ram_word;
    wire  [7:0]  cmd_data;
    wire         sda_line = sda_drv & (sda_oe_n | sda_out);
    integer      mismatches = 0, total_checks = 0, cycles = 0, ncmd = 0;

    always #10 sys_clk = ~sys_clk;

    lcdr_top u_dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(1'b1), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .addr_select_strap(strap), .hw_subaddr_pin_0(hw_sub[0]),
        .hw_subaddr_pin_1(hw_sub[1]), .hw_subaddr_pin_2(hw_sub[2]),
        .ram_valid(ram_valid), .ram_ready(ram_ready), .ram_word(ram_word),
        .cmd_valid(cmd_valid), .cmd_data(cmd_data), .busy(busy));
    lcdr_bus_ctrl u_bus (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

    // Run is a few thousand cycles; ceiling leaves wide margin
    always @(posedge sys_clk) begin
        cycles++;
        if (cmd_valid) begin
            ncmd++;
            last_cmd = cmd_data;
        end
        if (ram_valid && ram_ready) words.push_back(ram_word);
        if (cycles == 20000) begin
            mismatches++;
            end_of_test;
        end
    end

    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task xfer(input [7:0] b, input logic exp);
        u_bus.send(b, 8, ack);
        `CHK(ack, exp)
    endtask
    task chk_word(input [13:0] e);
        logic [13:0] w;
        w = (words.size() > 0) ? words.pop_front() : 14'h3FFF;
        `CHK(w, e)
    endtask
    task hdr(input [7:0] c1, input [7:0] c2);
        u_bus.start;
        xfer(8'h70, 1'b1);
        xfer(c1, 1'b1);
        xfer(c2, 1'b1);
    endtask

    task t_address;
        integer s, a;
        for (s = 0; s < 2; s++) begin
            for (a = 0; a < 4; a++) begin
                strap <= s[0];
                u_bus.start;
                xfer(8'h70 + a[7:0], a[0] == 1'b0 && a[1] == s[0]);
                xfer(8'h00, a[0] == 1'b0 && a[1] == s[0]);
                u_bus.stop;
                `CHK(busy, 1'b0)
            end
        end
        strap <= 1'b0;
        $display("t_address done");
    endtask
    task t_commands;
        integer k, n0;
        hw_sub <= 3'h5;
        u_bus.start;
        xfer(8'h70, 1'b1);
        n0 = ncmd;
        for (k = 0; k < 8; k++) xfer(8'hE0 + k[7:0], 1'b1);
        xfer(8'h05, 1'b1);
        `CHK(ncmd - n0, 9)
        `CHK(last_cmd, 8'h05)
        xfer(8'hA5, 1'b0);
        u_bus.stop;
        hdr(8'hE5, 8'h06);
        xfer(8'hA5, 1'b1);
        u_bus.stop;
        chk_word({6'h06, 8'hA5});
        $display("t_commands done");
    endtask
    task t_wrap;
        hw_sub <= 3'h0;
        hdr(8'hE0, 8'h26);
        xfer(8'h11, 1'b1);
        xfer(8'h22, 1'b1);
        xfer(8'h33, 1'b0);
        u_bus.stop;
        chk_word({6'h26, 8'h11});
        chk_word({6'h27, 8'h22});
        `CHK(words.size(), 0)
        $display("t_wrap done");
    endtask
    task t_fifo;
        integer i;
        ram_ready <= 1'b0;
        hdr(8'hE0, 8'h00);
        for (i = 0; i < 8; i++) xfer(8'h30 + i[7:0], 1'b1);
        xfer(8'h40, 1'b0);
        u_bus.stop;
        `CHK(ram_valid, 1'b1)
        ram_ready <= 1'b1;
        repeat (12) @(posedge sys_clk);
        for (i = 0; i < 8; i++) chk_word({i[5:0], 8'h30 + i[7:0]});
        `CHK(ram_valid, 1'b0)
        $display("t_fifo done");
    endtask
    task t_restart;
        u_bus.start;
        `CHK(busy, 1'b1)
        xfer(8'h70, 1'b1);
        u_bus.send(8'h80, 4, ack);
        u_bus.start;
        xfer(8'h70, 1'b1);
        xfer(8'h80, 1'b1);
        u_bus.start;
        xfer(8'h70, 1'b1);
        u_bus.stop;
        `CHK(busy, 1'b0)
        $display("t_restart done");
    endtask

    initial begin
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_address;
        t_commands;
        t_wrap;
        t_fifo;
        t_restart;
        end_of_test;
    end
endmodule // test_lcdr_top
